// File: common/pms_map.vh
// Constants of the power mode sequencer: register offsets, fields, resets, timing.
//
// Notes on behaviour
// - Valid input feeds system rail, charges battery.
// - Ship holds off until input or press.
// - Ship entry ignores charge enable input.
// - Battery insertion without input or press enters ship.
// - Ship request waits for input removal.
// - Ship request waits for pushbutton release.
// - Button wake from ship needs battery above maximum threshold.
// - Host clearing request cancels pending ship.
// - Watchdog expiry keeps ship request set.
// - Low power needs pin, input, button, idle.
// - Low power stops clocks and serial port.
// - Regulator output keeps its pre-entry state.
// - Pin high or input leaves low power.
// - Overvoltage input forces active battery mode.
// - Held pushbutton keeps active battery mode.
// - Battery-only and above threshold turns FET on.
// - Overcurrent turns the discharge FET off.
// - Battery undervoltage turns discharge FET off.
// - Input insertion wakes logic, feeds rail conditionally.
// - Battery insertion samples button, wake timer.
// - Serial, charge enable, pin gated by mode.
`ifndef PMS_MAP_VH
`define PMS_MAP_VH
`define PMS_ADDR_CTRL 4'h0
`define PMS_ADDR_STATUS 4'h1
`define PMS_ADDR_WAKE 4'h2
`define PMS_CTRL_SHIP_BIT 0
`define PMS_CTRL_CHG_EN_BIT 1
`define PMS_CTRL_LSR_EN_BIT 2
`define PMS_CTRL_RESET 8'h06
`define PMS_WAKE_TIME_US 16'd500
`define PMS_CLK_MHZ 16'd40
`define PMS_WAKE_CYCLES 32'd20000
`define PMS_MODE_OFF 3'h0
`define PMS_MODE_SHIP 3'h1
`define PMS_MODE_LOWPWR 3'h2
`define PMS_MODE_BATT 3'h3
`define PMS_MODE_CHARGE 3'h4
`define PMS_MODE_INSERT 3'h5
`define PMS_MODE_WAKE 3'h6
`endif

// File: rtl/pms_sync.v
// Two-flop synchroniser bank for asynchronous pins and comparators.
`timescale 1ns/1ps
module pms_sync #(
  parameter WIDTH = 8,
  parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
  input wire CLK,
  input wire RST,
  input wire [WIDTH-1:0] D,
  output wire [WIDTH-1:0] Q
);
  reg [WIDTH-1:0] meta;
  reg [WIDTH-1:0] stable;
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      always @(posedge CLK) begin
        if (RST) begin
          meta[i] <= INIT[i];
          stable[i] <= INIT[i];
        end else begin
          meta[i] <= D[i];
          stable[i] <= meta[i];
        end
      end
    end
  endgenerate
  assign Q = stable;
endmodule // pms_sync

// File: rtl/pms_timer.v
// Press timer that reports when a held level has lasted a set number of cycles.
`timescale 1ns/1ps
module pms_timer #(
  parameter WIDTH = 16
) (
  input wire CLK,
  input wire RST,
  input wire RUN,
  input wire [WIDTH-1:0] LIMIT,
  output reg DONE
);
  reg [WIDTH-1:0] count;
  always @(posedge CLK) begin
    if (RST || !RUN) begin
      count <= {WIDTH{1'b0}};
      DONE <= 1'b0;
    end else if (count >= LIMIT - 1'b1) begin
      DONE <= 1'b1;
    end else begin
      count <= count + 1'b1;
    end
  end
endmodule // pms_timer

// File: rtl/pms_power_mode_sequencer.v
// Power mode sequencer: mode controller with a small register port.
`timescale 1ns/1ps
`include "pms_map.vh"
module pms_power_mode_sequencer #(
  parameter WAKE_CYCLES = `PMS_WAKE_CYCLES
) (
  input wire CLK,
  input wire RST,
  input wire [3:0] ADDR,
  input wire [7:0] WDATA,
  input wire WR,
  input wire RD,
  output reg [7:0] RDATA,
  input wire IN_ABOVE_UVLO,
  input wire IN_ABOVE_OVP,
  input wire IN_ABOVE_DPM,
  input wire IN_ABOVE_BAT_SLP,
  input wire BAT_PRESENT,
  input wire BAT_ABOVE_UVLO,
  input wire BAT_ABOVE_MAX_UVLO,
  input wire BAT_OVERCURRENT,
  input wire PUSHBUTTON_N,
  input wire LOW_POWER_PIN_N,
  input wire CHARGE_ENABLE_N,
  input wire CHARGE_DONE,
  input wire SERIAL_BUSY,
  input wire INT_PENDING,
  input wire WATCHDOG_EXPIRED,
  output reg LOGIC_RAIL_EN,
  output reg SYSTEM_RAIL_FROM_INPUT,
  output reg BATTERY_DISCHARGE_FET_ON,
  output reg CHARGE_ON,
  output reg OSC_EN,
  output reg SERIAL_EN,
  output reg INT_EN,
  output reg LOAD_SWITCH_REGULATOR_OUTPUT,
  output reg [2:0] MODE
);
  wire [7:0] sync_q;
  wire in_uvlo;
  wire in_ovp;
  wire in_dpm;
  wire in_slp;
  wire bat_present;
  wire bat_uvlo;
  wire bat_max;
  wire pushbutton_n;
  wire low_power_pin_n;
  wire wake_done;
  wire in_valid;
  reg [2:0] state;
  reg [2:0] next_state;
  reg ship_request_bit;
  reg charge_enable_bit;
  reg load_switch_regulator_enable;
  reg lsr_latched;
  reg insert_wake;
  reg ocp_trip;
  reg run_wake;

  pms_sync #(
    .WIDTH(8),
    .INIT(8'hc0)
  ) u_sync (
    .CLK(CLK),
    .RST(RST),
    .D({LOW_POWER_PIN_N, PUSHBUTTON_N, BAT_ABOVE_MAX_UVLO, BAT_ABOVE_UVLO,
        BAT_PRESENT, IN_ABOVE_BAT_SLP, IN_ABOVE_DPM, IN_ABOVE_UVLO}),
    .Q(sync_q)
  );
  assign in_uvlo = sync_q[0];
  assign in_dpm = sync_q[1];
  assign in_slp = sync_q[2];
  assign bat_present = sync_q[3];
  assign bat_uvlo = sync_q[4];
  assign bat_max = sync_q[5];
  assign pushbutton_n = sync_q[6];
  assign low_power_pin_n = sync_q[7];

  pms_sync #(
    .WIDTH(1),
    .INIT(1'b0)
  ) u_sync_ovp (
    .CLK(CLK),
    .RST(RST),
    .D(IN_ABOVE_OVP),
    .Q(in_ovp)
  );

  // An adapter above the overvoltage level is present but never counts as a valid input.
  assign in_valid = in_uvlo && !in_ovp;

  pms_timer #(
    .WIDTH(32)
  ) u_wake (
    .CLK(CLK),
    .RST(RST),
    .RUN(run_wake),
    .LIMIT(WAKE_CYCLES),
    .DONE(wake_done)
  );

  always @* begin
    run_wake = !pushbutton_n &&
      (state == `PMS_MODE_SHIP || state == `PMS_MODE_WAKE);
  end

  // Mode transitions.
  always @* begin
    next_state = state;
    case (state)
      `PMS_MODE_OFF: begin
        if (in_uvlo) begin
          next_state = `PMS_MODE_CHARGE;
        end else if (bat_present && bat_uvlo) begin
          next_state = `PMS_MODE_INSERT;
        end
      end
      `PMS_MODE_INSERT: begin
        if (in_uvlo) begin
          next_state = `PMS_MODE_CHARGE;
        end else if (pushbutton_n) begin
          next_state = `PMS_MODE_SHIP;
        end else begin
          next_state = `PMS_MODE_WAKE;
        end
      end
      `PMS_MODE_SHIP: begin
        if (in_uvlo) begin
          next_state = `PMS_MODE_CHARGE;
        end else if (!bat_present) begin
          next_state = `PMS_MODE_OFF;
        end else if (!pushbutton_n && bat_max) begin
          next_state = `PMS_MODE_WAKE;
        end
      end
      `PMS_MODE_WAKE: begin
        if (in_uvlo) begin
          next_state = `PMS_MODE_CHARGE;
        end else if (pushbutton_n) begin
          // Press released: wake only if held long enough.
          next_state = wake_done ? `PMS_MODE_BATT : `PMS_MODE_SHIP;
        end else if (wake_done && insert_wake) begin
          next_state = `PMS_MODE_BATT;
        end
      end
      `PMS_MODE_CHARGE: begin
        if (!in_valid) begin
          if (ship_request_bit && pushbutton_n) begin
            next_state = `PMS_MODE_SHIP;
          end else begin
            next_state = `PMS_MODE_BATT;
          end
        end
      end
      `PMS_MODE_BATT: begin
        if (in_valid) begin
          next_state = `PMS_MODE_CHARGE;
        end else if (!bat_present) begin
          // A removed battery leaves nothing to run from.
          next_state = `PMS_MODE_OFF;
        end else if (ship_request_bit && pushbutton_n) begin
          next_state = `PMS_MODE_SHIP;
        end else if (!low_power_pin_n && pushbutton_n && !in_ovp &&
                     !SERIAL_BUSY && !INT_PENDING) begin
          next_state = `PMS_MODE_LOWPWR;
        end
      end
      `PMS_MODE_LOWPWR: begin
        if (in_valid) begin
          next_state = `PMS_MODE_CHARGE;
        end else if (!bat_present) begin
          next_state = `PMS_MODE_OFF;
        end else if (low_power_pin_n || !pushbutton_n || in_ovp) begin
          next_state = `PMS_MODE_BATT;
        end
      end
      default: begin
        next_state = `PMS_MODE_OFF;
      end
    endcase
  end

  always @(posedge CLK) begin
    if (RST) begin
      state <= `PMS_MODE_OFF;
      insert_wake <= 1'b0;
    end else begin
      state <= next_state;
      // A wake begun at battery insertion powers up while held; one from ship needs release.
      if (state == `PMS_MODE_INSERT) begin
        insert_wake <= 1'b1;
      end else if (state != `PMS_MODE_WAKE) begin
        insert_wake <= 1'b0;
      end
    end
  end

  // Register port. Writes are only accepted in charge and battery modes; reads work in every mode.
  always @(posedge CLK) begin
    if (RST) begin
      ship_request_bit <= 1'b0;
      charge_enable_bit <= 1'b1;
      load_switch_regulator_enable <= 1'b1;
      RDATA <= 8'h00;
    end else begin
      if (WR && SERIAL_EN && ADDR == `PMS_ADDR_CTRL) begin
        ship_request_bit <= WDATA[`PMS_CTRL_SHIP_BIT];
        charge_enable_bit <= WDATA[`PMS_CTRL_CHG_EN_BIT];
        load_switch_regulator_enable <= WDATA[`PMS_CTRL_LSR_EN_BIT];
      end else if (state == `PMS_MODE_SHIP) begin
        ship_request_bit <= 1'b0;
      end
      if (RD) begin
        case (ADDR)
          `PMS_ADDR_CTRL: RDATA <= {5'h00, load_switch_regulator_enable,
                                    charge_enable_bit, ship_request_bit};
          `PMS_ADDR_STATUS: RDATA <= {ocp_trip, WATCHDOG_EXPIRED, bat_uvlo,
                                      in_uvlo, 1'b0, state};
          default: RDATA <= 8'hff;
        endcase
      end
    end
  end

  // Overcurrent latch, released by a valid input or by ship mode.
  always @(posedge CLK) begin
    if (RST) begin
      ocp_trip <= 1'b0;
    end else if (BAT_OVERCURRENT) begin
      ocp_trip <= 1'b1;
    end else if (in_valid || state == `PMS_MODE_SHIP) begin
      ocp_trip <= 1'b0;
    end
  end

  // Regulator state frozen across low power.
  always @(posedge CLK) begin
    if (RST) begin
      lsr_latched <= 1'b0;
    end else if (state != `PMS_MODE_LOWPWR) begin
      lsr_latched <= load_switch_regulator_enable;
    end
  end

  always @(posedge CLK) begin
    if (RST) begin
      LOGIC_RAIL_EN <= 1'b0;
      SYSTEM_RAIL_FROM_INPUT <= 1'b0;
      BATTERY_DISCHARGE_FET_ON <= 1'b0;
      CHARGE_ON <= 1'b0;
      OSC_EN <= 1'b1;
      SERIAL_EN <= 1'b0;
      INT_EN <= 1'b0;
      LOAD_SWITCH_REGULATOR_OUTPUT <= 1'b0;
      MODE <= `PMS_MODE_OFF;
    end else begin
      MODE <= state;
      LOGIC_RAIL_EN <= state != `PMS_MODE_SHIP && state != `PMS_MODE_OFF;
      SYSTEM_RAIL_FROM_INPUT <= state == `PMS_MODE_CHARGE && in_slp && !in_ovp && in_dpm;
      CHARGE_ON <= state == `PMS_MODE_CHARGE && in_dpm && !in_ovp &&
                   charge_enable_bit && !charge_blocked(CHARGE_ENABLE_N, CHARGE_DONE);
      BATTERY_DISCHARGE_FET_ON <= (state == `PMS_MODE_BATT ||
                                   state == `PMS_MODE_LOWPWR) &&
                                  bat_uvlo && !ocp_trip && !BAT_OVERCURRENT;
      OSC_EN <= state != `PMS_MODE_LOWPWR && state != `PMS_MODE_SHIP;
      SERIAL_EN <= state == `PMS_MODE_CHARGE || state == `PMS_MODE_BATT;
      INT_EN <= state == `PMS_MODE_CHARGE || state == `PMS_MODE_BATT;
      LOAD_SWITCH_REGULATOR_OUTPUT <= (state == `PMS_MODE_LOWPWR) ? lsr_latched :
        ((state == `PMS_MODE_CHARGE || state == `PMS_MODE_BATT) &&
         load_switch_regulator_enable);
    end
  end

  // Charging is blocked by the pin being high or by termination.
  function charge_blocked;
    input ce_n;
    input done;
    begin
      charge_blocked = ce_n | done;
    end
  endfunction
endmodule // pms_power_mode_sequencer

// File: dv/pms_props.sv
// Checker of mode, gating and rail relations at the sequencer ports.
`timescale 1ns/1ps
`include "pms_map.vh"
module pms_props #(
  parameter WAKE_CYCLES = 8
) (
  input wire CLK,
  input wire RST,
  input wire [3:0] ADDR,
  input wire RD,
  input wire [7:0] RDATA,
  input wire IN_ABOVE_UVLO,
  input wire IN_ABOVE_OVP,
  input wire IN_ABOVE_BAT_SLP,
  input wire BAT_ABOVE_UVLO,
  input wire BAT_OVERCURRENT,
  input wire BATTERY_DISCHARGE_FET_ON,
  input wire CHARGE_ON,
  input wire OSC_EN,
  input wire SERIAL_EN,
  input wire [2:0] MODE
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  // Outputs are registered from the same state as the mode, yet some checks still wait for the mode to settle.
  ship_fet_off_a: assert property ((MODE == `PMS_MODE_SHIP) [*2] |-> !BATTERY_DISCHARGE_FET_ON)
    else $error("fet on in ship");
  serial_mode_gate_a: assert property (SERIAL_EN && $stable(MODE) |->
    MODE == `PMS_MODE_BATT || MODE == `PMS_MODE_CHARGE) else $error("serial on in wrong mode");
  lowpwr_clock_off_a: assert property (MODE == `PMS_MODE_LOWPWR && $stable(MODE) |->
    !OSC_EN && !SERIAL_EN) else $error("clock or serial on in low power");
  charge_gate_a: assert property ($rose(CHARGE_ON) |-> MODE == `PMS_MODE_CHARGE)
    else $error("charging outside charge mode");
  ocp_fet_off_a: assert property ((BAT_OVERCURRENT && !IN_ABOVE_UVLO) [*6] |->
    !BATTERY_DISCHARGE_FET_ON) else $error("fet on during overcurrent");
  batuv_fet_off_a: assert property ((!BAT_ABOVE_UVLO && !IN_ABOVE_UVLO) [*6] |->
    !BATTERY_DISCHARGE_FET_ON) else $error("fet on below battery threshold");
  input_wake_a: assert property ((IN_ABOVE_UVLO && !IN_ABOVE_OVP && IN_ABOVE_BAT_SLP) [*6] |->
    MODE == `PMS_MODE_CHARGE) else $error("valid input without charge mode");
  unmapped_read_a: assert property (RD && ADDR > 4'h2 |=> RDATA == 8'hff)
    else $error("unmapped read not ff");
  ship_seen_c: cover property (MODE == `PMS_MODE_SHIP);
  lowpwr_seen_c: cover property (MODE == `PMS_MODE_LOWPWR);
  charge_seen_c: cover property (MODE == `PMS_MODE_CHARGE);
endmodule // pms_props
bind pms_power_mode_sequencer pms_props #(.WAKE_CYCLES(WAKE_CYCLES)) u_props (.CLK, .RST,
  .ADDR, .RD, .RDATA, .IN_ABOVE_UVLO, .IN_ABOVE_OVP, .IN_ABOVE_BAT_SLP, .BAT_ABOVE_UVLO,
  .BAT_OVERCURRENT, .BATTERY_DISCHARGE_FET_ON, .CHARGE_ON, .OSC_EN, .SERIAL_EN, .MODE);

// File: dv/pms_world.sv
// Model of adapter, battery and pushbutton as seen by the sequencer.
`timescale 1ns/1ps
module pms_world (
  input wire CLK,
  input wire RST,
  input wire [5:0] ENV,
  input wire LOW_POWER_PIN_N,
  input wire RAILS_UP,
  output wire IN_ABOVE_UVLO,
  output wire IN_ABOVE_OVP,
  output wire IN_ABOVE_DPM,
  output wire IN_ABOVE_BAT_SLP,
  output wire BAT_PRESENT,
  output wire BAT_ABOVE_UVLO,
  output wire BAT_ABOVE_MAX_UVLO,
  output wire PUSHBUTTON_N
);
  reg hold;
  always @(posedge CLK) begin
    if (RST) begin
      hold <= !LOW_POWER_PIN_N;
    end else if (RAILS_UP) begin
      hold <= 1'b0;
    end
  end
  // An overvoltage adapter is also above the undervoltage level but never feeds the rail.
  assign IN_ABOVE_UVLO = ENV[0] | ENV[1];
  assign IN_ABOVE_OVP = ENV[1];
  assign IN_ABOVE_DPM = ENV[0];
  assign IN_ABOVE_BAT_SLP = ENV[0];
  assign BAT_PRESENT = ENV[2];
  assign BAT_ABOVE_UVLO = ENV[2] & ENV[3];
  assign BAT_ABOVE_MAX_UVLO = ENV[2] & ENV[4];
  assign PUSHBUTTON_N = !(ENV[5] | hold);
endmodule // pms_world

// File: dv/testbench.sv
// Self-checking bench driving modes through adapter, battery, button, pin and registers.
`timescale 1ns/1ps
`include "pms_map.vh"
module testbench;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg [3:0] addr = 4'h0;
  reg [7:0] wdata = 8'h00;
  reg wr = 1'b0;
  reg rd = 1'b0;
  reg [5:0] env = 6'h1d;
  reg lp_n = 1'b1;
  reg ce_n = 1'b0;
  reg busy = 1'b0;
  reg wdog = 1'b0;
  reg ocp = 1'b0;
  wire [7:0] rdata;
  wire [2:0] mode;
  wire in_uv, in_ov, in_dpm, in_slp, bat_p, bat_uv, bat_max, btn_n;
  wire rail, sys_in, fet, chg, osc, ser, int_en, ls;
  integer n_mismatch = 0;
  integer total_checks = 0;
  integer i;
  initial begin
    forever #12.5 clk = ~clk;
  end
  pms_world w_env (.CLK(clk), .RST(rst), .ENV(env), .LOW_POWER_PIN_N(lp_n),
    .RAILS_UP(fet | sys_in), .IN_ABOVE_UVLO(in_uv), .IN_ABOVE_OVP(in_ov), .IN_ABOVE_DPM(in_dpm),
    .IN_ABOVE_BAT_SLP(in_slp), .BAT_PRESENT(bat_p), .BAT_ABOVE_UVLO(bat_uv),
    .BAT_ABOVE_MAX_UVLO(bat_max), .PUSHBUTTON_N(btn_n));
  pms_power_mode_sequencer #(.WAKE_CYCLES(8)) uut (.CLK(clk), .RST(rst), .ADDR(addr),
    .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .IN_ABOVE_UVLO(in_uv), .IN_ABOVE_OVP(in_ov),
    .IN_ABOVE_DPM(in_dpm), .IN_ABOVE_BAT_SLP(in_slp), .BAT_PRESENT(bat_p),
    .BAT_ABOVE_UVLO(bat_uv), .BAT_ABOVE_MAX_UVLO(bat_max), .BAT_OVERCURRENT(ocp),
    .PUSHBUTTON_N(btn_n), .LOW_POWER_PIN_N(lp_n), .CHARGE_ENABLE_N(ce_n), .CHARGE_DONE(1'b0),
    .SERIAL_BUSY(busy), .INT_PENDING(1'b0), .WATCHDOG_EXPIRED(wdog), .LOGIC_RAIL_EN(rail),
    .SYSTEM_RAIL_FROM_INPUT(sys_in), .BATTERY_DISCHARGE_FET_ON(fet), .CHARGE_ON(chg),
    .OSC_EN(osc), .SERIAL_EN(ser), .INT_EN(int_en), .LOAD_SWITCH_REGULATOR_OUTPUT(ls),
    .MODE(mode));
  task chk(input [7:0] got, input [7:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task give_verdict;
    begin
      if (n_mismatch == 0 && total_checks > 0) begin
        $display("Simulation passed");
      end else begin
        $display("Simulation failed");
      end
      $finish;
    end
  endtask
  task cyc(input integer n);
    begin
      repeat (n) @(posedge clk);
    end
  endtask
  task wr_reg(input [3:0] a, input [7:0] d);
    begin
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      @(posedge clk);
    end
  endtask
  task rd_chk(input [3:0] a, input [7:0] exp);
    begin
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(posedge clk);
      chk(rdata, exp);
    end
  endtask
  // A mode that never arrives ends the run instead of hanging it.
  task wait_mode(input [2:0] m);
    begin
      i = 0;
      while (mode !== m && i < 400) begin
        @(posedge clk);
        i = i + 1;
      end
      chk({5'h0, mode}, {5'h0, m});
      if (mode !== m) give_verdict;
    end
  endtask
  initial begin
    cyc(12);
    rst <= 1'b0;
    wait_mode(`PMS_MODE_CHARGE);
    cyc(2);
    chk({4'h0, rail, int_en, chg, sys_in}, 8'h0f);
    rd_chk(`PMS_ADDR_STATUS, 8'h34);
    rd_chk(`PMS_ADDR_CTRL, `PMS_CTRL_RESET);
    rd_chk(4'hf, 8'hff);
    ce_n <= 1'b1;
    cyc(8);
    chk({7'h0, chg}, 8'h00);
    ce_n <= 1'b0;
    wr_reg(`PMS_ADDR_CTRL, 8'h07);
    cyc(20);
    chk({5'h0, mode}, {5'h0, `PMS_MODE_CHARGE});
    wr_reg(`PMS_ADDR_CTRL, 8'h06);
    env <= 6'h1c;
    cyc(30);
    chk({4'h0, mode, fet}, {4'h0, `PMS_MODE_BATT, 1'b1});
    env <= 6'h3c;
    wdog <= 1'b1;
    ce_n <= 1'b1;
    cyc(4);
    wr_reg(`PMS_ADDR_CTRL, 8'h07);
    cyc(20);
    chk({5'h0, mode}, {5'h0, `PMS_MODE_BATT});
    rd_chk(`PMS_ADDR_STATUS, 8'h63);
    env <= 6'h1c;
    wait_mode(`PMS_MODE_SHIP);
    cyc(2);
    chk({6'h0, rail, fet}, 8'h00);
    wdog <= 1'b0;
    ce_n <= 1'b0;
    env <= 6'h2c;
    cyc(30);
    env <= 6'h0c;
    cyc(20);
    chk({5'h0, mode}, {5'h0, `PMS_MODE_SHIP});
    env <= 6'h3c;
    cyc(30);
    chk({5'h0, mode}, {5'h0, `PMS_MODE_WAKE});
    env <= 6'h1c;
    wait_mode(`PMS_MODE_BATT);
    busy <= 1'b1;
    lp_n <= 1'b0;
    cyc(20);
    chk({5'h0, mode}, {5'h0, `PMS_MODE_BATT});
    busy <= 1'b0;
    wait_mode(`PMS_MODE_LOWPWR);
    cyc(2);
    chk({3'h0, rail, int_en, osc, ser, ls}, 8'h11);
    env <= 6'h3c;
    wait_mode(`PMS_MODE_BATT);
    env <= 6'h1c;
    wait_mode(`PMS_MODE_LOWPWR);
    env <= 6'h1e;
    wait_mode(`PMS_MODE_BATT);
    env <= 6'h1c;
    wait_mode(`PMS_MODE_LOWPWR);
    lp_n <= 1'b1;
    wait_mode(`PMS_MODE_BATT);
    env <= 6'h14;
    cyc(10);
    chk({7'h0, fet}, 8'h00);
    env <= 6'h1c;
    cyc(10);
    chk({7'h0, fet}, 8'h01);
    ocp <= 1'b1;
    cyc(10);
    chk({7'h0, fet}, 8'h00);
    ocp <= 1'b0;
    env <= 6'h00;
    cyc(20);
    env <= 6'h1c;
    wait_mode(`PMS_MODE_SHIP);
    env <= 6'h1d;
    wait_mode(`PMS_MODE_CHARGE);
    env <= 6'h00;
    cyc(20);
    env <= 6'h3c;
    wait_mode(`PMS_MODE_BATT);
    // Reset with the low-power pin low: the button model must hold until the rails are up.
    lp_n <= 1'b0;
    env <= 6'h1c;
    rst <= 1'b1;
    cyc(12);
    rst <= 1'b0;
    wait_mode(`PMS_MODE_BATT);
    wait_mode(`PMS_MODE_LOWPWR);
    give_verdict;
  end
endmodule // testbench
